// ===== hw/sbct_line_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sbct_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport mon (output scl, output sda, output scl_rise, output scl_fall, output start_det, output stop_det);
  modport core (input scl, input sda, input scl_rise, input scl_fall, input start_det, input stop_det);
endinterface
`default_nettype wire

// ===== hw/sbct_line_mon.sv
`timescale 1ns/1ps
`default_nettype none
module sbct_line_mon (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bus pins and enable
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic en,
  // Conditioned lines
  sbct_line_if.mon line
);
  logic [1:0] pins;
  logic [1:0] stage1;
  logic [1:0] stage2;
  logic [1:0] prev;

  assign pins = {sda_pin, scl_pin};

  // Two-flop synchroniser per line
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        stage1[i] <= 1'b1;
        stage2[i] <= 1'b1;
        prev[i] <= 1'b1;
      end else begin
        stage1[i] <= pins[i];
        stage2[i] <= stage1[i];
        prev[i] <= stage2[i];
      end
    end
  end

  assign line.scl = stage2[0];
  assign line.sda = stage2[1];
  assign line.scl_rise = en & stage2[0] & ~prev[0];
  assign line.scl_fall = en & ~stage2[0] & prev[0];
  assign line.start_det = en & stage2[0] & prev[0] & prev[1] & ~stage2[1];
  assign line.stop_det = en & stage2[0] & prev[0] & ~prev[1] & stage2[1];
endmodule
`default_nettype wire

// ===== hw/sbct_pkg.sv
package sbct_pkg;
  // Configuration register
  localparam logic [7:0] CFG_ADDR = 8'hc1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'hdf;
  localparam int BIT_EN = 7;
  localparam int BIT_INH = 6;
  localparam int BIT_BUSY = 5;
  localparam int BIT_EXT = 4;
  localparam int BIT_TOE = 3;
  localparam int BIT_FTE = 2;
  localparam int BIT_CS_HI = 1;
  localparam int BIT_CS_LO = 0;
  // Clock source codes
  localparam logic [1:0] CS_T0 = 2'h0;
  localparam logic [1:0] CS_T1 = 2'h1;
  localparam logic [1:0] CS_T2H = 2'h2;
  localparam logic [1:0] CS_T2L = 2'h3;
  // Bit and bus free timing in overflows
  localparam logic [1:0] LOW_OVF = 2'h1;
  localparam logic [1:0] HIGH_OVF = 2'h2;
  localparam logic [3:0] FREE_OVF = 4'ha;
  localparam logic [3:0] FREE_DONE = 4'hb;
  // Data timing in system clocks
  localparam logic [3:0] HOLD_NORM = 4'h3;
  localparam logic [3:0] HOLD_EXT = 4'hc;
  localparam logic [3:0] SETUP_EXT = 4'hb;
  localparam logic [3:0] CNT_SAT = 4'hf;
  // Master clock states
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_LOW = 2'b01,
    MS_WAIT_HIGH = 2'b10,
    MS_HIGH = 2'b11
  } sbct_mstate_t;
endpackage

// ===== hw/sbct_top.sv
`timescale 1ns/1ps
`default_nettype none
module sbct_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Timer overflows and timeout timer control
  input wire logic [3:0] tmr_ovf,
  output logic tmo_reload,
  output logic tmo_count,
  // Transfer engine side
  input wire logic master_active,
  input wire logic core_hold,
  input wire logic sda_value,
  input wire logic cond_gen,
  input wire logic start_pend,
  input wire logic master_ev,
  input wire logic slave_ev,
  output logic start_now,
  output logic bus_busy,
  output logic irq,
  // Bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe
);
  sbct_line_if line ();

  logic [7:0] cfg;
  logic busy;
  logic inh_eff;
  logic sda_low;
  logic [3:0] hold_cnt;
  logic [3:0] setup_cnt;
  logic [3:0] free_cnt;
  logic [3:0] next_free_cnt;
  logic [1:0] ovf_cnt;
  logic [1:0] next_ovf_cnt;
  sbct_pkg::sbct_mstate_t state_q;
  sbct_pkg::sbct_mstate_t next_state;

  wire en = cfg[sbct_pkg::BIT_EN];
  wire slave_inhibit = cfg[sbct_pkg::BIT_INH];
  wire ext = cfg[sbct_pkg::BIT_EXT];
  wire toe = cfg[sbct_pkg::BIT_TOE];
  wire fte = cfg[sbct_pkg::BIT_FTE];
  wire [1:0] cs = cfg[sbct_pkg::BIT_CS_HI:sbct_pkg::BIT_CS_LO];
  wire cfg_sel = (sfr_addr == sbct_pkg::CFG_ADDR);
  wire cfg_wr = sfr_wr & cfg_sel;
  wire [7:0] cfg_view = {cfg[7:6], busy, cfg[4:0]};
  wire ovf_sel = tmr_ovf[cs];
  wire both_high = line.scl & line.sda;
  wire free_hit = en & fte & both_high & ovf_sel & (free_cnt == sbct_pkg::FREE_OVF);
  wire [3:0] hold_min = ext ? sbct_pkg::HOLD_EXT : sbct_pkg::HOLD_NORM;
  wire hold_ok = ~line.scl & ~line.scl_fall & (hold_cnt >= hold_min);
  wire sda_upd = en & (hold_ok | cond_gen);
  wire next_sda_low = sda_upd ? ~sda_value : sda_low;
  wire setup_ok = (next_sda_low == sda_low) & (~ext | (setup_cnt >= sbct_pkg::SETUP_EXT));
  wire low_done = (ovf_cnt == sbct_pkg::LOW_OVF) & ~core_hold & setup_ok;
  wire high_done = ovf_sel & (ovf_cnt == (sbct_pkg::HIGH_OVF - 2'h1));

  sbct_line_mon u_mon (
    .clock(clock),
    .rst_b(rst_b),
    .scl_pin(scl_in),
    .sda_pin(sda_in),
    .en(en),
    .line(line)
  );

  // Register port
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= sbct_pkg::CFG_RESET;
      sfr_rdata <= 8'h00;
    end else begin
      if (cfg_wr) begin
        cfg <= sfr_wdata & sbct_pkg::CFG_WMASK;
      end
      sfr_rdata <= (sfr_rd & cfg_sel) ? cfg_view : 8'h00;
    end
  end

  // Busy flag and inhibit capture
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      inh_eff <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (!en) begin
        busy <= 1'b0;
      end else if (line.start_det) begin
        busy <= 1'b1;
      end else if (line.stop_det | free_hit) begin
        busy <= 1'b0;
      end
      if (line.start_det) begin
        inh_eff <= slave_inhibit;
      end
      irq <= en & (master_ev | (slave_ev & ~inh_eff));
    end
  end

  // Bus free counter
  always_comb begin
    next_free_cnt = free_cnt;
    if (!en || !fte || !both_high) begin
      next_free_cnt = 4'h0;
    end else if (ovf_sel && free_cnt != sbct_pkg::FREE_DONE) begin
      next_free_cnt = free_cnt + 4'h1;
    end
  end

  // Master clock generator
  always_comb begin
    next_state = state_q;
    next_ovf_cnt = ovf_cnt;
    case (state_q)
      sbct_pkg::MS_IDLE: begin
        next_ovf_cnt = 2'h0;
        if (master_active) begin
          next_state = sbct_pkg::MS_LOW;
        end
      end
      sbct_pkg::MS_LOW: begin
        if (low_done) begin
          next_state = sbct_pkg::MS_WAIT_HIGH;
          next_ovf_cnt = 2'h0;
        end else if (ovf_sel && ovf_cnt != sbct_pkg::LOW_OVF) begin
          next_ovf_cnt = ovf_cnt + 2'h1;
        end
      end
      sbct_pkg::MS_WAIT_HIGH: begin
        if (line.scl) begin
          next_state = sbct_pkg::MS_HIGH;
        end
      end
      sbct_pkg::MS_HIGH: begin
        if (!line.scl || high_done) begin
          next_state = master_active ? sbct_pkg::MS_LOW : sbct_pkg::MS_IDLE;
          next_ovf_cnt = 2'h0;
        end else if (ovf_sel) begin
          next_ovf_cnt = ovf_cnt + 2'h1;
        end
      end
      default: begin
        next_state = sbct_pkg::MS_IDLE;
        next_ovf_cnt = 2'h0;
      end
    endcase
    if (!en) begin
      next_state = sbct_pkg::MS_IDLE;
      next_ovf_cnt = 2'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= sbct_pkg::MS_IDLE;
      ovf_cnt <= 2'h0;
      free_cnt <= 4'h0;
    end else begin
      state_q <= next_state;
      ovf_cnt <= next_ovf_cnt;
      free_cnt <= next_free_cnt;
    end
  end

  // Data line timing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sda_low <= 1'b0;
      hold_cnt <= sbct_pkg::CNT_SAT;
      setup_cnt <= sbct_pkg::CNT_SAT;
    end else begin
      sda_low <= en & next_sda_low;
      if (line.scl_fall) begin
        hold_cnt <= 4'h0;
      end else if (hold_cnt != sbct_pkg::CNT_SAT) begin
        hold_cnt <= hold_cnt + 4'h1;
      end
      if (next_sda_low != sda_low) begin
        setup_cnt <= 4'h0;
      end else if (setup_cnt != sbct_pkg::CNT_SAT) begin
        setup_cnt <= setup_cnt + 4'h1;
      end
    end
  end

  // Outputs
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = (state_q == sbct_pkg::MS_LOW);
  assign sda_oe = sda_low;
  assign bus_busy = busy;
  assign tmo_reload = en & toe & line.scl;
  assign tmo_count = en & toe & ~line.scl;
  assign start_now = en & start_pend & ~master_active & (free_hit | ~busy);

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_fall_ext;
    line.scl_fall && ext && !cond_gen;
  endsequence
  sequence s_fall_norm;
    line.scl_fall && !ext && !cond_gen;
  endsequence
  sequence s_release;
    (state_q == sbct_pkg::MS_LOW) ##1 (state_q == sbct_pkg::MS_WAIT_HIGH);
  endsequence

  AST_HOLD_EXT: assert property (s_fall_ext |=> $stable(sda_oe)[*8] ##1 $stable(sda_oe)[*4])
    else $error("extended hold shorter than twelve clocks");
  AST_HOLD_NORM: assert property (s_fall_norm |=> $stable(sda_oe)[*3])
    else $error("normal hold shorter than three clocks");
  AST_SETUP_EXT: assert property (s_release |-> $stable(sda_oe) && (!$past(ext) || $past(setup_cnt) >= sbct_pkg::SETUP_EXT))
    else $error("clock released before extended setup");
  AST_LOW_MIN: assert property (s_release |-> $past(ovf_cnt) == sbct_pkg::LOW_OVF && !$past(core_hold))
    else $error("clock low shorter than one overflow");
  AST_HIGH_EXIT: assert property ((state_q == sbct_pkg::MS_HIGH) ##1 (state_q != sbct_pkg::MS_HIGH)
    |-> !$past(en) || !$past(line.scl) || ($past(ovf_sel) && $past(ovf_cnt) == 2'h1))
    else $error("clock high left before two overflows");
  AST_TMO: assert property ((en && toe && line.scl) |-> tmo_reload && !tmo_count)
    else $error("timeout timer counts while clock high");
  AST_BUSY_CLR: assert property ((line.stop_det || free_hit) && !line.start_det |=> !bus_busy)
    else $error("busy not cleared by stop or free timeout");
  AST_BUSY_SET: assert property ((en && line.start_det) |=> bus_busy ##1
    (bus_busy || !$past(en) || $past(line.stop_det) || $past(free_hit)))
    else $error("busy not set by start");
  AST_INH: assert property ((inh_eff && slave_ev && !master_ev) |=> !irq)
    else $error("slave interrupt raised while inhibited");
  AST_FREE_RST: assert property ((!line.scl || !line.sda) |=> free_cnt == 4'h0)
    else $error("free counter not restarted by low line");
  AST_START: assert property ((free_hit && start_pend && !master_active) |-> start_now)
    else $error("start not issued on free timeout");
  AST_DISABLE: assert property (!en |=> !scl_oe && !sda_oe)
    else $error("lines driven while disabled");
endmodule
`default_nettype wire

// ===== verification/sbct_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
module sbct_bus_peer (
  // Device open-drain enables
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Resolved lines
  output logic scl,
  output logic sda
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // Pull-ups, wired AND
  assign scl = ~(scl_oe | scl_low);
  assign sda = ~(sda_oe | sda_low);
  // Stretching only holds the clock low
  task automatic scl_hold(input logic on);
    scl_low = on;
  endtask
  // Half link period between steps
  task automatic start_cond();
    sda_low = 1'b1;
    #40 scl_low = 1'b1;
    #40 sda_low = 1'b0;
  endtask
  task automatic stop_cond();
    scl_low = 1'b1;
    sda_low = 1'b1;
    #40 scl_low = 1'b0;
    #40 sda_low = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verification/test_smbus_clock_timing_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_smbus_clock_timing_config;
  localparam logic [7:0] CFG = sbct_pkg::CFG_ADDR;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [3:0] tmr_ovf = 4'h0;
  logic tmo_reload, tmo_count, start_now, bus_busy, irq;
  logic master_active = 1'b0;
  logic start_pend = 1'b0;
  logic master_ev = 1'b0;
  logic slave_ev = 1'b0;
  logic core_hold = 1'b0;
  logic sda_value = 1'b1;
  logic cond_gen = 1'b0;
  logic scl_out, sda_out;
  logic scl, sda, scl_oe, sda_oe;
  logic [7:0] d;
  int failures = 0;
  int num_checks = 0;
  always #2.5 clock = ~clock;
  sbct_top sbct_top_inst (.clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tmr_ovf(tmr_ovf),
    .tmo_reload(tmo_reload), .tmo_count(tmo_count), .master_active(master_active),
    .core_hold(core_hold), .sda_value(sda_value), .cond_gen(cond_gen), .start_pend(start_pend),
    .master_ev(master_ev), .slave_ev(slave_ev), .start_now(start_now), .bus_busy(bus_busy),
    .irq(irq), .scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe));
  sbct_bus_peer sbct_bus_peer_inst (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    v = sfr_rdata;
    sfr_rd = 1'b0;
  endtask
  // One-clock overflow pulse on the given sources, then all sources idle
  task automatic pulse(input logic [3:0] v);
    @(negedge clock);
    tmr_ovf = v;
    @(negedge clock);
    tmr_ovf = 4'h0;
  endtask
  task automatic evp(input logic m, input logic s);
    @(negedge clock);
    master_ev = m;
    slave_ev = s;
    @(negedge clock);
    master_ev = 1'b0;
    slave_ev = 1'b0;
  endtask
  task automatic t_regs();
    rd(CFG, d);
    check(d, 8'h00);
    wr(CFG, 8'hff);
    rd(CFG, d);
    check(d, 8'hdf);
    wr(8'hc0, 8'h00);
    rd(CFG, d);
    check(d, 8'hdf);
    rd(8'hc0, d);
    check(d, 8'h00);
    wr(CFG, 8'h00);
    $display("regs done");
  endtask
  task automatic t_tmo();
    wr(CFG, 8'h88);
    cyc(4);
    check({6'h00, tmo_reload, tmo_count}, 8'h02);
    sbct_bus_peer_inst.scl_hold(1'b1);
    cyc(4);
    check({6'h00, tmo_reload, tmo_count}, 8'h01);
    // Timeout handler restarts the interface
    wr(CFG, 8'h08);
    check({6'h00, tmo_reload, tmo_count}, 8'h00);
    wr(CFG, 8'h88);
    check({6'h00, tmo_reload, tmo_count}, 8'h01);
    wr(CFG, 8'h80);
    check({6'h00, tmo_reload, tmo_count}, 8'h00);
    sbct_bus_peer_inst.scl_hold(1'b0);
    cyc(4);
    $display("timeout timer done");
  endtask
  task automatic t_busy();
    wr(CFG, 8'h87);
    start_pend = 1'b1;
    sbct_bus_peer_inst.start_cond();
    cyc(6);
    check(8'(bus_busy), 8'h01);
    sbct_bus_peer_inst.stop_cond();
    cyc(6);
    check(8'(bus_busy), 8'h00);
    check(8'(start_now), 8'h01);
    sbct_bus_peer_inst.start_cond();
    sbct_bus_peer_inst.scl_hold(1'b0);
    cyc(6);
    check(8'(start_now), 8'h00);
    repeat (5) pulse(4'h8);
    sbct_bus_peer_inst.scl_hold(1'b1);
    cyc(4);
    sbct_bus_peer_inst.scl_hold(1'b0);
    cyc(4);
    repeat (10) begin
      pulse(4'h8);
      pulse(4'h7);
    end
    rd(CFG, d);
    check(d, 8'ha7);
    pulse(4'h8);
    cyc(2);
    check(8'(bus_busy), 8'h00);
    check(8'(start_now), 8'h01);
    start_pend = 1'b0;
    wr(CFG, 8'h00);
    $display("busy and free timeout done");
  endtask
  task automatic t_master();
    for (int i = 0; i < 4; i++) begin
      wr(CFG, 8'h80 | 8'(i));
      master_active = 1'b1;
      cyc(3);
      check(8'(scl_oe), 8'h01);
      pulse(~(4'h1 << i));
      cyc(3);
      check(8'(scl_oe), 8'h01);
      sbct_bus_peer_inst.scl_hold(1'b1);
      pulse(4'h1 << i);
      cyc(3);
      check(8'(scl_oe), 8'h00);
      pulse(4'h1 << i);
      pulse(4'h1 << i);
      sbct_bus_peer_inst.scl_hold(1'b0);
      cyc(4);
      pulse(4'h1 << i);
      cyc(3);
      check(8'(scl_oe), 8'h00);
      pulse(4'h1 << i);
      cyc(3);
      check(8'(scl_oe), 8'h01);
      master_active = 1'b0;
      wr(CFG, 8'h00);
      cyc(2);
      check(8'(scl_oe), 8'h00);
    end
    $display("master clock done");
  endtask
  task automatic t_irq();
    wr(CFG, 8'h80);
    evp(1'b0, 1'b1);
    check(8'(irq), 8'h01);
    wr(CFG, 8'hc0);
    sbct_bus_peer_inst.start_cond();
    cyc(6);
    evp(1'b0, 1'b1);
    check(8'(irq), 8'h00);
    evp(1'b1, 1'b0);
    check(8'(irq), 8'h01);
    wr(CFG, 8'h00);
    cyc(2);
    check(8'(bus_busy), 8'h00);
    sbct_bus_peer_inst.scl_hold(1'b0);
    $display("interrupt done");
  endtask
  // Data line: condition bypass, then hold after a far-side clock fall
  task automatic t_data(input logic ext);
    int h;
    h = ext ? 12 : 3;
    wr(CFG, ext ? 8'h90 : 8'h80);
    cond_gen = 1'b1;
    sda_value = 1'b0;
    cyc(1);
    check(8'(sda_oe), 8'h01);
    cyc(4);
    check(8'(bus_busy), 8'h01);
    sda_value = 1'b1;
    cyc(1);
    check(8'(sda_oe), 8'h00);
    cyc(4);
    check(8'(bus_busy), 8'h00);
    cond_gen = 1'b0;
    sda_value = 1'b0;
    sbct_bus_peer_inst.scl_hold(1'b1);
    // Two sync stages and the fall edge come before the hold count
    cyc(h + 3);
    check(8'(sda_oe), 8'h00);
    cyc(1);
    check(8'(sda_oe), 8'h01);
    sda_value = 1'b1;
    cyc(2);
    check(8'(sda_oe), 8'h00);
    sbct_bus_peer_inst.scl_hold(1'b0);
    cyc(4);
    check({6'h00, scl_out, sda_out}, 8'h00);
    wr(CFG, 8'h00);
    $display("data line done");
  endtask
  // Master release waits for data setup after a stall
  task automatic t_setup(input logic ext);
    int n;
    n = ext ? 12 : 1;
    wr(CFG, ext ? 8'h90 : 8'h80);
    core_hold = 1'b1;
    master_active = 1'b1;
    cyc(20);
    pulse(4'h1);
    cyc(4);
    check(8'(scl_oe), 8'h01);
    sda_value = 1'b0;
    core_hold = 1'b0;
    cyc(n);
    check({6'h00, scl_oe, sda_oe}, 8'h03);
    cyc(1);
    check({6'h00, scl_oe, sda_oe}, 8'h01);
    master_active = 1'b0;
    wr(CFG, 8'h00);
    sda_value = 1'b1;
    cyc(4);
    check(8'(sda_oe), 8'h00);
    $display("setup done");
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    summarize();
  end
  initial begin
    cyc(4);
    rst_b = 1'b1;
    t_regs();
    t_tmo();
    t_busy();
    t_master();
    t_irq();
    t_data(1'b0);
    t_data(1'b1);
    t_setup(1'b0);
    t_setup(1'b1);
    summarize();
  end
endmodule
`default_nettype wire
